// ### verilog/sram_consts.svh
// Offsets, field positions, reset values and timing counts for the sleep and cycle logic.
// Summary of operation
// - While sleeping, act deselected, ignore inputs except sleep, float the data bus.
// - Sleep request is asynchronous, active high; sleep lasts while it stays high.
// - Inputs stop being honoured at most two clocks after sleep request rises.
// - Synchronous inputs are sampled again from the third clock after sleep request falls.
// - Low sleep-current state is reached within two clocks of sleep request rising.
// - Burst order input low selects linear order, high selects interleaved order.
// - Selected only when both low selects are low and the high select is high.
// - Reads return newest data, forwarding from the write input register if needed.
// - Clock hold high makes the edge a pause; no write happens on that edge.
// - A stalled edge keeps a read driving the bus and a write floating it.
// - Linear order counts the two low address bits upward modulo four.
// - Interleaved order XORs the loaded low bits with 00, 01, 10, 11 in turn.
// - Each active-low byte write enables its own lane; all high aborts the write.
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH
`define CTRL_OFFSET       12'h000
`define STATUS_OFFSET     12'h004
`define CTRL_FORCE_BIT    0
`define ST_ASLEEP_BIT     0
`define ST_RECOVER_BIT    1
`define ST_BURST_BIT      2
`define ST_BADWR_BIT      3
`define CTRL_RESET        1'b0
`define SLEEP_SYNC_RESET  2'b00
`define SLEEP_SYNC_SET    2'b11
`define RECOVERY_PERIODS  2'd2
`define BURST_START       2'b00
`define BURST_STEP        2'b01
`endif

// ### verilog/sram_pkg.sv
// Types shared by the sleep and cycle logic.
package sram_pkg;
  // Kind of burst started by the last load cycle.
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_e;

  // One qualified memory cycle as decoded on an edge.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [18:0] addr;
    logic [3:0]  be;
  } cycle_s;
endpackage

// ### verilog/burst_seq.sv
// Two-bit burst address sequencer for linear and interleaved orders.
`timescale 1ns/1ps
module burst_seq (
  input  wire logic       interleaved,
  input  wire logic [1:0] start,
  input  wire logic [1:0] step,
  output logic      [1:0] low_bits
);
  // Interleaved order XORs, linear order adds modulo four; the step counts beats after the load.
  always_comb begin
    if (interleaved) begin
      low_bits = start ^ step;
    end else begin
      low_bits = 2'(start + step);
    end
  end
endmodule

// ### verilog/sram_sleep_ctrl.sv
// Flow-through synchronous SRAM core with sleep entry and exit and an APB status port.
`timescale 1ns/1ps
`include "sram_consts.svh"
module sram_sleep_ctrl
  import sram_pkg::*;
#(
  parameter int ADDR_W = 19,
  parameter int LANE_W = 9
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [ADDR_W-1:0]   address,
  input  wire logic                chip_select_low,
  input  wire logic                second_select_low,
  input  wire logic                second_select_high,
  input  wire logic                advance_or_load,
  input  wire logic                write_low,
  input  wire logic                byte_lane_a_write_low,
  input  wire logic                byte_lane_b_write_low,
  input  wire logic                byte_lane_c_write_low,
  input  wire logic                byte_lane_d_write_low,
  input  wire logic                clock_hold_low,
  input  wire logic                output_enable_low,
  input  wire logic                burst_interleaved,
  input  wire logic                sleep_request,
  input  wire logic [4*LANE_W-1:0] dq_in,
  output logic      [4*LANE_W-1:0] dq_out,
  output logic                     dq_oe,
  output logic                     sleep_supply_current
);
  localparam int DEPTH = 1 << ADDR_W;

  logic              force_sleep;
  logic              sleep_any;
  logic [1:0]        sleep_sync;
  logic              asleep;
  logic              active_edge;
  logic              selected;
  logic [3:0]        lane_we;
  op_e               op;
  logic [ADDR_W-1:0] base;
  logic [1:0]        burst_cnt;
  logic [1:0]        next_step;
  logic [1:0]        seq_bits;
  cycle_s            cyc;
  cycle_s            pend;
  logic [ADDR_W-1:0] cur_addr;
  logic [ADDR_W-1:0] pend_addr;
  logic              wr_valid;
  logic [ADDR_W-1:0] wr_addr;
  logic [4*LANE_W-1:0] wr_data;
  logic [3:0]        wr_be;
  logic [4*LANE_W-1:0] rd_data;
  logic [1:0]        rec_cnt;
  logic              bad_write;
  logic              apb_acc;
  logic              apb_done;
  logic              addr_ok;
  logic [31:0]       rd_mux;

  // Software sleep and the pin both enter sleep at once; only the release is clocked.
  assign sleep_any = sleep_request | force_sleep;

  // Set asynchronously, released through two flops so exit is glitch free.
  always_ff @(posedge pclk or negedge presetn or posedge sleep_any) begin
    if (!presetn) begin
      sleep_sync <= `SLEEP_SYNC_RESET;
    end else if (sleep_any) begin
      sleep_sync <= `SLEEP_SYNC_SET;
    end else begin
      sleep_sync <= {sleep_sync[0], 1'b0};
    end
  end

  assign asleep = sleep_sync[1];
  assign sleep_supply_current = asleep;

  // A stalled edge changes no cycle state (the recovery count still runs), so reads keep driving and writes stay floating.
  assign active_edge = ~asleep & ~clock_hold_low;
  assign selected = ~chip_select_low & ~second_select_low & second_select_high;
  assign lane_we = ~{byte_lane_d_write_low, byte_lane_c_write_low,
                     byte_lane_b_write_low, byte_lane_a_write_low};
  assign next_step = 2'(burst_cnt + `BURST_STEP);

  burst_seq u_seq (
    .interleaved (burst_interleaved),
    .start       (base[1:0]),
    .step        (next_step),
    .low_bits    (seq_bits)
  );

  // Decode the cycle presented on this edge; advance continues the loaded burst.
  always_comb begin
    cyc = '0;
    cyc.be = lane_we;
    if (!advance_or_load) begin
      cyc.valid = selected;
      cyc.write = ~write_low;
      cyc.addr  = 19'(address);
    end else begin
      cyc.valid = (op != OP_IDLE);
      cyc.write = (op == OP_WRITE);
      cyc.addr  = 19'({base[ADDR_W-1:2], seq_bits});
    end
  end

  // The cycle record is sized for the full part; the array sees only its own width.
  assign cur_addr  = ADDR_W'(cyc.addr);
  assign pend_addr = ADDR_W'(pend.addr);

  // Burst state; sleep clears it so exit starts deselected with no burst.
  always_ff @(posedge pclk or negedge presetn or posedge asleep) begin
    if (!presetn) begin
      op        <= OP_IDLE;
      base      <= '0;
      burst_cnt <= `BURST_START;
    end else if (asleep) begin
      op        <= OP_IDLE;
      base      <= '0;
      burst_cnt <= `BURST_START;
    end else if (active_edge) begin
      if (!advance_or_load) begin
        base      <= address;
        burst_cnt <= `BURST_START;
        if (!selected) begin
          op <= OP_IDLE;
        end else if (!write_low) begin
          op <= OP_WRITE;
        end else begin
          op <= OP_READ;
        end
      end else if (op != OP_IDLE) begin
        burst_cnt <= next_step;
      end
    end
  end

  // Late write: data follows its address by one edge, then waits one more in the input register.
  always_ff @(posedge pclk or negedge presetn or posedge asleep) begin
    if (!presetn) begin
      pend     <= '0;
      wr_valid <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_be    <= '0;
    end else if (asleep) begin
      pend     <= '0;
      wr_valid <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_be    <= '0;
    end else if (active_edge) begin
      pend.valid <= cyc.valid & cyc.write & (|cyc.be);
      pend.write <= cyc.write;
      pend.addr  <= cyc.addr;
      pend.be    <= cyc.be;
      wr_valid   <= pend.valid;
      if (pend.valid) begin
        wr_addr <= pend_addr;
        wr_data <= dq_in;
        wr_be   <= pend.be;
      end
    end
  end

  // One array per lane, so each byte write touches only its own lane.
  for (genvar i = 0; i < 4; i++) begin : g_lane
    logic [LANE_W-1:0] mem [DEPTH];

    always_ff @(posedge pclk) begin
      if (active_edge && wr_valid && wr_be[i]) begin
        mem[wr_addr] <= wr_data[i*LANE_W +: LANE_W];
      end
    end

    // Newest data wins: data on the pins now, then the input register, then the array.
    always_comb begin
      if (pend.valid && pend.be[i] && pend.addr == cyc.addr) begin
        rd_data[i*LANE_W +: LANE_W] = dq_in[i*LANE_W +: LANE_W];
      end else if (wr_valid && wr_be[i] && wr_addr == cur_addr) begin
        rd_data[i*LANE_W +: LANE_W] = wr_data[i*LANE_W +: LANE_W];
      end else begin
        rd_data[i*LANE_W +: LANE_W] = mem[cur_addr];
      end
    end
  end

  // Flow-through read data and bus drive; writes and deselects float the bus.
  always_ff @(posedge pclk or negedge presetn or posedge asleep) begin
    if (!presetn) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (asleep) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (active_edge) begin
      dq_oe <= cyc.valid & ~cyc.write & ~output_enable_low;
      if (cyc.valid && !cyc.write) begin
        dq_out <= rd_data;
      end
    end
  end

  // Recovery window after exit; the count restarts at every sleep.
  always_ff @(posedge pclk or negedge presetn or posedge asleep) begin
    if (!presetn) begin
      rec_cnt <= '0;
    end else if (asleep) begin
      rec_cnt <= `RECOVERY_PERIODS;
    end else if (rec_cnt != '0) begin
      rec_cnt <= 2'(rec_cnt - 2'd1);
    end
  end

  // APB: one wait state so the read data can leave a flop.
  assign apb_acc = psel & penable;
  assign apb_done = apb_acc & pready;
  assign addr_ok = (paddr == `CTRL_OFFSET) || (paddr == `STATUS_OFFSET);

  always_comb begin
    rd_mux = '0;
    if (paddr == `CTRL_OFFSET) begin
      rd_mux[`CTRL_FORCE_BIT] = force_sleep;
    end else if (paddr == `STATUS_OFFSET) begin
      rd_mux[`ST_ASLEEP_BIT]  = asleep;
      rd_mux[`ST_RECOVER_BIT] = (rec_cnt != '0);
      rd_mux[`ST_BURST_BIT]   = (op != OP_IDLE);
      rd_mux[`ST_BADWR_BIT]   = bad_write;
    end
  end

  // Bus handshake and read capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= apb_acc & ~pready;
      pslverr <= apb_acc & ~pready & ~addr_ok;
      if (apb_acc && !pready && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // Control register steers software sleep.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_sleep <= `CTRL_RESET;
    end else if (apb_done && pwrite && paddr == `CTRL_OFFSET) begin
      force_sleep <= pwdata[`CTRL_FORCE_BIT];
    end
  end

  // Sticky flag for a write seen during recovery; a new event beats the clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_write <= 1'b0;
    end else if (active_edge && rec_cnt != '0 && cyc.valid && cyc.write) begin
      bad_write <= 1'b1;
    end else if (apb_done && pwrite && paddr == `STATUS_OFFSET &&
                 pwdata[`ST_BADWR_BIT]) begin
      bad_write <= 1'b0;
    end
  end
endmodule

// ### bench/sram_sleep_ctrl_properties.sv
// Checker of sleep, select and stall behaviour at the memory pins.
`timescale 1ns/1ps
module sram_sleep_ctrl_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic advance_or_load,
  input wire logic clock_hold_low,
  input wire logic write_low,
  input wire logic chip_select_low,
  input wire logic second_select_low,
  input wire logic second_select_high,
  input wire logic output_enable_low,
  input wire logic sleep_request,
  input wire logic dq_oe,
  input wire logic sleep_supply_current
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An edge honoured as a new cycle; a stall or sleep makes it count for nothing.
  sequence load;
    !advance_or_load && !clock_hold_low && !sleep_request;
  endsequence
  sequence rd_load;
    load ##0 write_low && !output_enable_low && !chip_select_low && !second_select_low
      && second_select_high;
  endsequence
  chk_sleep_float: assert property (sleep_request |-> !dq_oe)
    else $error("bus driven while asleep");
  chk_sleep_settle: assert property ($rose(sleep_request) |-> ##[0:2]
    sleep_supply_current) else $error("low current state late");
  chk_sleep_level: assert property (sleep_request [*3] |-> sleep_supply_current)
    else $error("low current state dropped");
  chk_wake_quiet: assert property ($fell(sleep_request) |-> !dq_oe [*2])
    else $error("bus driven on wake");
  chk_wake_read: assert property ($fell(sleep_request) ##2 rd_load |=> dq_oe)
    else $error("read ignored after wake");
  chk_desel_float: assert property (load ##0 (chip_select_low || second_select_low
    || !second_select_high) |=> !dq_oe) else $error("deselected part drives bus");
  chk_write_float: assert property (load ##0 !write_low |=> !dq_oe)
    else $error("bus driven in write");
  chk_stall_hold: assert property (clock_hold_low && !sleep_request ##1 !sleep_request
    |-> $stable(dq_oe)) else $error("stalled edge moved the bus");
endmodule
bind sram_sleep_ctrl sram_sleep_ctrl_properties chk_u (.*);

// ### bench/mem_ctrl_model.sv
// Behavioural memory controller that issues cycles to the core.
`timescale 1ns/1ps
module mem_ctrl_model (
  input  wire logic   pclk,
  output logic [5:0]  address,
  output logic        chip_select_low,
  output logic        second_select_low,
  output logic        second_select_high,
  output logic        advance_or_load,
  output logic        write_low,
  output logic [3:0]  lanes,
  output logic        clock_hold_low,
  output logic        output_enable_low,
  output logic        burst_interleaved,
  output logic        sleep_request,
  output logic [35:0] dq_in
);
  logic [35:0] pend;
  logic        pw;
  logic [2:0]  bad;
  logic        mode;
  logic        oe_n;
  // Start deselected; output enable stays low even for writes unless a test lifts it.
  initial begin
    {address, pend, pw, bad, mode, oe_n, clock_hold_low, output_enable_low} = '0;
    {burst_interleaved, sleep_request, dq_in} = '0;
    {second_select_high, second_select_low, chip_select_low} = 3'b101;
    {advance_or_load, write_low, lanes} = '1;
  end
  // One edge: 0 deselect, 1 read, 2 write, 3 continue, 4 stall.
  // Write data follows its address by one edge, lanes go with it; idle data toggles.
  task automatic cyc(input int op, input logic [5:0] a, input logic [3:0] bl,
                     input logic [35:0] d);
    @(posedge pclk);
    clock_hold_low <= (op == 4);
    if (op != 4) begin
      {second_select_high, second_select_low, chip_select_low} <=
        op ? 3'b100 ^ bad : 3'b101;
      burst_interleaved <= mode;
      output_enable_low <= oe_n;
      advance_or_load <= (op == 3);
      write_low       <= (op != 2);
      address         <= a;
      dq_in           <= pw ? pend : ~dq_in;
      if (op == 2 || !pw)
        lanes <= bl;
      pw = (op == 2);
      pend = d;
    end
    #1;
  endtask
  // Sleep waits for queued writes to land; only a deselect follows a change.
  task automatic snooze(input logic v);
    if (v)
      repeat (2) cyc(0, 0, 4'hf, 0);
    @(posedge pclk);
    sleep_request <= v;
    cyc(0, 0, 4'hf, 0);
  endtask
endmodule

// ### bench/sram_sleep_ctrl_tb_top.sv
// Bench for the core: register port, memory cycles, stalls and sleep.
`timescale 1ns/1ps
module sram_sleep_ctrl_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        chip_select_low, second_select_low, second_select_high, advance_or_load;
  logic        write_low, clock_hold_low, output_enable_low, burst_interleaved;
  logic        sleep_request, dq_oe, sleep_supply_current;
  logic [3:0]  lanes;
  logic [5:0]  address;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [35:0] dq_in, dq_out;
  logic [35:0] mem [64];
  int          miscompares, total_checks, cycles;

  sram_sleep_ctrl #(.ADDR_W(6), .LANE_W(9)) dut_u (.*, .byte_lane_a_write_low(lanes[0]),
    .byte_lane_b_write_low(lanes[1]), .byte_lane_c_write_low(lanes[2]),
    .byte_lane_d_write_low(lanes[3]));
  mem_ctrl_model ctl_u (.*);

  // Free-running 20 MHz clock.
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  // A hang ends the run; the tests need far fewer edges than this.
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Register access; the request stands until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [3:0] bl, input logic [35:0] d);
    ctl_u.cyc(2, a, bl, d);
    for (int i = 0; i < 4; i++)
      if (!bl[i]) mem[a][i*9 +: 9] = d[i*9 +: 9];
  endtask
  // Burst read; each beat's word follows from the order input and the load address.
  task automatic rdb(input logic [5:0] a, input int n);
    logic [1:0] lo;
    ctl_u.cyc(1, a, 4'hf, 0);
    for (int i = 0; i < n; i++) begin
      lo = burst_interleaved ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
      ctl_u.cyc(i < n - 1 ? 3 : 0, a, 4'hf, 0);
      chk(dq_out, mem[{a[5:2], lo}]);
      chk(dq_oe, 1);
    end
  endtask
  // Reset, then registers, writes, bursts, selects, stalls and sleep.
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h004, 0);
    chk(rd, 0);
    apb(0, 12'h008, 0);
    chk({rd, er}, 1);
    apb(1, 12'h000, 1);
    apb(0, 12'h004, 0);
    chk({rd[0], dq_oe}, 2'b10);
    apb(1, 12'h000, 0);
    repeat (3) ctl_u.cyc(0, 0, 4'hf, 0);
    for (int i = 0; i < 4; i++)
      wr(6'(8 + i), 0, 36'h111111111 * 36'(i + 1));
    for (int m = 0; m < 2; m++) begin
      ctl_u.mode = m[0];
      rdb(6'd9, 4);
    end
    for (int i = 0; i < 4; i++)
      wr(6'd20, ~(4'b0001 << i), {4{9'(i * 37 + 5)}});
    wr(6'd20, 4'hf, '1);
    rdb(6'd20, 1);
    for (int b = 1; b < 8; b = b * 2) begin
      ctl_u.cyc(1, 6'd8, 4'hf, 0);
      ctl_u.bad = 3'(b);
      ctl_u.cyc(1, 6'd8, 4'hf, 0);
      ctl_u.bad = 0;
      ctl_u.cyc(0, 0, 4'hf, 0);
      chk(dq_oe, 0);
    end
    ctl_u.oe_n = 1;
    ctl_u.cyc(1, 6'd8, 4'hf, 0);
    apb(0, 12'h004, 0);
    chk({rd, dq_oe}, 33'h8);
    ctl_u.oe_n = 0;
    ctl_u.cyc(1, 6'd8, 4'hf, 0);
    ctl_u.cyc(4, 0, 0, 0);
    ctl_u.cyc(0, 0, 4'hf, 0);
    chk(dq_out, mem[8]);
    chk(dq_oe, 1);
    wr(6'd9, 0, 36'h5a5a5a5a5);
    ctl_u.cyc(4, 0, 0, 0);
    rdb(6'd9, 1);
    ctl_u.snooze(1);
    ctl_u.cyc(2, 6'd20, 0, 0);
    ctl_u.cyc(1, 6'd20, 4'hf, 0);
    chk({sleep_supply_current, dq_oe}, 2'b10);
    ctl_u.snooze(0);
    rdb(6'd20, 1);
    apb(0, 12'h004, 0);
    chk(rd, 0);
    finish_test();
  end
endmodule
